// >>> core/clk_check_pkg.sv
// Constants, field layout and carrier types for the transmit clock check block.
// Assumes a 32-bit APB register bus and a single 250 MHz system clock.
//
// Summary of operation
// [RQ1] Count prescaled system clocks over every window of 32 master clock cycles.
// [RQ2] Latch the 8-bit count into bits 31-24 at each window end, hold it.
// [RQ3] Set the failure flag when the count is above the upper bound, unsigned.
// [RQ4] Set the failure flag when the count is below the lower bound, unsigned.
// [RQ5] Bit 7 enables automatic switching on a detected failure.
// [RQ6] Bits 3-0 divide the counted clock by two to the code; 9h-Fh reserved.
// [RQ7] Bits 6-4 read as zero and ignore writes; software writes zero.
// [RQ8] Failure flag clears only by writing one; it raises the transmit interrupt.
// [RQ9] The check counter clears at each window start; measured count resets to zero.
package clk_check_pkg;

    // Register byte offsets on the APB bus.
    localparam logic [11:0] OFF_CHECK_CTRL = 12'h0C8;
    localparam logic [11:0] OFF_TX_STATUS  = 12'h080;
    localparam logic [11:0] OFF_INT_MASK   = 12'h084;

    // Field positions of the check control register.
    localparam int CNT_LSB       = 24;
    localparam int UPPER_LSB     = 16;
    localparam int LOWER_LSB     = 8;
    localparam int AUTOSW_BIT    = 7;
    localparam int PRESCALE_LSB  = 0;

    // Bit of the failure flag in the status and mask registers.
    localparam int FAIL_BIT      = 2;

    // Window length in master clock cycles and the largest legal prescale code.
    localparam int          WINDOW_CYCLES = 32;
    localparam logic [3:0]  PRESCALE_MAX  = 4'h8;

    // Reset values.
    localparam logic [7:0]  RST_COUNT     = 8'h00;
    localparam logic [7:0]  RST_BOUND     = 8'h00;
    localparam logic [3:0]  RST_PRESCALE  = 4'h0;
    localparam logic [31:0] RST_WORD      = 32'h0000_0000;

    // Software-written configuration of the checker.
    typedef struct packed {
        logic [7:0] upper_bound;
        logic [7:0] lower_bound;
        logic       fail_autoswitch_enable;
        logic [3:0] check_prescale;
    } check_ctrl_type;

    // One APB request as the slave sees it.
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_type;

endpackage

// >>> core/prescale_tick.sv
// Prescaler that yields one enable pulse every 2^code system clocks.
// Assumes the code is already limited to the legal range 0 to 8.
`timescale 1ns/1ps

module prescale_tick (
    input  wire logic       i_clk,
    input  wire logic       i_rstn,
    input  wire logic [3:0] i_code,
    output logic            o_tick
);

    logic [7:0] div_ff;
    logic [7:0] nxt_div;
    logic [7:0] low_mask;
    logic [3:0] shift_amt;

    // A mask of code ones; the tick fires when those low bits are all set.
    assign shift_amt = clk_check_pkg::PRESCALE_MAX - i_code;
    assign low_mask  = 8'hFF >> shift_amt;
    assign o_tick    = ((div_ff & low_mask) == low_mask); // [RQ6]
    assign nxt_div   = div_ff + 8'h01;

    // Free-running divider; phase is not tied to the window, so a count may be off by one.
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            div_ff <= 8'h00;
        end else begin
            div_ff <= nxt_div;
        end
    end

endmodule

// >>> core/tx_clock_failure_check.sv
// Transmit clock failure checker with APB register access and a level interrupt.
// Assumes the master clock input is sampled as a synchronous level on i_clk and is
// much slower than i_clk, so each of its rising edges is seen as one sampled edge.
//
// Implementation choice: register access over APB.
`timescale 1ns/1ps

module tx_clock_failure_check (
    input  wire logic        i_clk,
    input  wire logic        i_rstn,
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [11:0] i_paddr,
    input  wire logic [31:0] i_pwdata,
    input  wire logic [3:0]  i_pstrb,
    output logic             o_pready,
    output logic [31:0]      o_prdata,
    output logic             o_pslverr,
    input  wire logic        i_tx_high_freq_master_clock,
    output logic             o_tx_interrupt,
    output logic             o_autoswitch_request
);

    clk_check_pkg::apb_req_type    req;
    clk_check_pkg::check_ctrl_type ctrl_ff;
    clk_check_pkg::check_ctrl_type nxt_ctrl;

    logic        pready_ff;
    logic [31:0] prdata_ff;
    logic        pslverr_ff;
    logic        irq_ff;
    logic        autosw_ff;

    logic        mclk_prev_ff;
    logic [4:0]  edge_cnt_ff;
    logic [4:0]  nxt_edge_cnt;
    logic [7:0]  check_cnt_ff;
    logic [7:0]  nxt_check_cnt;
    logic [7:0]  measured_count_ff;
    logic [7:0]  nxt_measured_count;
    logic        fail_flag_ff;
    logic        nxt_fail_flag;
    logic        fail_mask_ff;
    logic        nxt_fail_mask;

    logic        access;
    logic        xfer_done;
    logic        wr_done;
    logic        sel_ctrl;
    logic        sel_status;
    logic        sel_mask;
    logic        addr_hit;
    logic [31:0] rd_word;
    logic [31:0] ctrl_word;
    logic [31:0] status_word;
    logic [31:0] mask_word;
    logic [31:0] wmask;
    logic [31:0] wr_ctrl;

    logic        mclk_rise;
    logic        window_end;
    logic        tick;
    logic [3:0]  eff_prescale;
    logic [8:0]  cnt_sum;
    logic [7:0]  cnt_sat;
    logic        too_high;
    logic        too_low;
    logic        fail_event;
    logic        fail_clear;

    // Bundle the bus inputs so the decode reads as one request.
    assign req = '{psel:    i_psel,
                   penable: i_penable,
                   pwrite:  i_pwrite,
                   paddr:   i_paddr,
                   pwdata:  i_pwdata};

    // Address decode; every access gets one wait state so read data comes from a flop.
    assign access     = req.psel && req.penable && !pready_ff;
    assign xfer_done  = req.psel && req.penable && pready_ff;
    assign sel_ctrl   = (req.paddr == clk_check_pkg::OFF_CHECK_CTRL);
    assign sel_status = (req.paddr == clk_check_pkg::OFF_TX_STATUS);
    assign sel_mask   = (req.paddr == clk_check_pkg::OFF_INT_MASK);
    assign addr_hit   = sel_ctrl || sel_status || sel_mask;
    assign wr_done    = xfer_done && req.pwrite && addr_hit;

    // Byte strobes widen into a bit mask; unstrobed bytes keep their old value.
    assign wmask = {{8{i_pstrb[3]}}, {8{i_pstrb[2]}}, {8{i_pstrb[1]}}, {8{i_pstrb[0]}}};

    // Read images; bits 6-4 of the control word are constant zero. [RQ7]
    assign ctrl_word = {measured_count_ff,
                        ctrl_ff.upper_bound,
                        ctrl_ff.lower_bound,
                        ctrl_ff.fail_autoswitch_enable,
                        3'b000,
                        ctrl_ff.check_prescale};
    assign status_word = {29'h0000_0000, fail_flag_ff, 2'b00};
    assign mask_word   = {29'h0000_0000, fail_mask_ff, 2'b00};

    // Read multiplexer; an unmapped address reads as zero.
    assign rd_word = sel_ctrl   ? ctrl_word   :
                     sel_status ? status_word :
                     sel_mask   ? mask_word   : clk_check_pkg::RST_WORD;

    // Merge strobed write data into the control image before splitting it into fields.
    assign wr_ctrl = (ctrl_word & ~wmask) | (req.pwdata & wmask);

    // Control register next value; the measured count field is read-only. [RQ2] [RQ7]
    always_comb begin
        nxt_ctrl = ctrl_ff;
        if (wr_done && sel_ctrl) begin
            nxt_ctrl.upper_bound            = wr_ctrl[clk_check_pkg::UPPER_LSB +: 8];
            nxt_ctrl.lower_bound            = wr_ctrl[clk_check_pkg::LOWER_LSB +: 8];
            nxt_ctrl.fail_autoswitch_enable = wr_ctrl[clk_check_pkg::AUTOSW_BIT]; // [RQ5]
            nxt_ctrl.check_prescale         = wr_ctrl[clk_check_pkg::PRESCALE_LSB +: 4];
        end
    end

    // Mask register: one bit, same position as the flag.
    assign nxt_fail_mask = (wr_done && sel_mask && i_pstrb[0])
                         ? req.pwdata[clk_check_pkg::FAIL_BIT] : fail_mask_ff;

    // Reserved prescale codes would be meaningless, so they act as the largest divider.
    assign eff_prescale = (ctrl_ff.check_prescale > clk_check_pkg::PRESCALE_MAX)
                        ? clk_check_pkg::PRESCALE_MAX : ctrl_ff.check_prescale; // [RQ6]

    prescale_tick u_prescale (
        .i_clk  (i_clk),
        .i_rstn (i_rstn),
        .i_code (eff_prescale),
        .o_tick (tick)
    );

    // Window tracking on sampled master clock rising edges.
    assign mclk_rise    = i_tx_high_freq_master_clock && !mclk_prev_ff;
    assign window_end   = mclk_rise && (edge_cnt_ff == 5'(clk_check_pkg::WINDOW_CYCLES - 1));
    assign nxt_edge_cnt = mclk_rise ? edge_cnt_ff + 5'd1 : edge_cnt_ff; // [RQ1]

    // The count saturates at 255 so a very slow master clock still reads as too high.
    assign cnt_sum = {1'b0, check_cnt_ff} + {8'h00, tick};
    assign cnt_sat = cnt_sum[8] ? 8'hFF : cnt_sum[7:0];

    // A tick in the closing cycle still belongs to the window that ends; then restart. [RQ9]
    assign nxt_check_cnt = window_end ? clk_check_pkg::RST_COUNT : cnt_sat; // [RQ1]

    // The last complete measurement is held until the next window closes. [RQ2]
    assign nxt_measured_count = window_end ? cnt_sat : measured_count_ff;

    // Unsigned bound checks on the closing count.
    assign too_high   = (cnt_sat > ctrl_ff.upper_bound); // [RQ3]
    assign too_low    = (cnt_sat < ctrl_ff.lower_bound); // [RQ4]
    assign fail_event = window_end && (too_high || too_low);

    // Write one to clear; a failure in the same cycle keeps the flag set. [RQ8]
    assign fail_clear    = wr_done && sel_status && i_pstrb[0]
                        && req.pwdata[clk_check_pkg::FAIL_BIT];
    assign nxt_fail_flag = fail_event || (fail_flag_ff && !fail_clear); // [RQ8]

    // Bus answer registers.
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            pready_ff  <= 1'b0;
            prdata_ff  <= clk_check_pkg::RST_WORD;
            pslverr_ff <= 1'b0;
        end else begin
            pready_ff  <= access;
            prdata_ff  <= (access && !req.pwrite) ? rd_word : clk_check_pkg::RST_WORD;
            pslverr_ff <= access && !addr_hit;
        end
    end

    // Software-visible configuration.
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            ctrl_ff.upper_bound            <= clk_check_pkg::RST_BOUND;
            ctrl_ff.lower_bound            <= clk_check_pkg::RST_BOUND;
            ctrl_ff.fail_autoswitch_enable <= 1'b0;
            ctrl_ff.check_prescale         <= clk_check_pkg::RST_PRESCALE;
            fail_mask_ff                   <= 1'b0;
        end else begin
            ctrl_ff      <= nxt_ctrl;
            fail_mask_ff <= nxt_fail_mask;
        end
    end

    // Measurement state.
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            mclk_prev_ff      <= 1'b0;
            edge_cnt_ff       <= 5'd0;
            check_cnt_ff      <= clk_check_pkg::RST_COUNT;
            measured_count_ff <= clk_check_pkg::RST_COUNT; // [RQ9]
        end else begin
            mclk_prev_ff      <= i_tx_high_freq_master_clock;
            edge_cnt_ff       <= nxt_edge_cnt;
            check_cnt_ff      <= nxt_check_cnt;
            measured_count_ff <= nxt_measured_count;
        end
    end

    // Flag, interrupt and autoswitch request; outputs lag the flag by one cycle.
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            fail_flag_ff <= 1'b0;
            irq_ff       <= 1'b0;
            autosw_ff    <= 1'b0;
        end else begin
            fail_flag_ff <= nxt_fail_flag;
            irq_ff       <= fail_flag_ff && fail_mask_ff; // [RQ8]
            autosw_ff    <= fail_flag_ff && ctrl_ff.fail_autoswitch_enable; // [RQ5]
        end
    end

    assign o_pready             = pready_ff;
    assign o_prdata             = prdata_ff;
    assign o_pslverr            = pslverr_ff;
    assign o_tx_interrupt       = irq_ff;
    assign o_autoswitch_request = autosw_ff;

endmodule

// >>> dv/tx_clock_failure_check_monitor.sv
// Concurrent checks on the ports of the transmit clock check block.
// Assumes one clock domain and the register map of the package.
`timescale 1ns/1ps

module tx_check_monitor (
    input wire logic        i_clk,
    input wire logic        i_rstn,
    input wire logic        i_psel,
    input wire logic        i_penable,
    input wire logic        i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [3:0]  i_pstrb,
    input wire logic        o_pready,
    input wire logic [31:0] o_prdata,
    input wire logic        o_pslverr,
    input wire logic        i_tx_high_freq_master_clock,
    input wire logic        o_tx_interrupt,
    input wire logic        o_autoswitch_request
);
    // Decode of the request, which the master holds while the answer stands.
    wire is_ctrl = i_paddr == clk_check_pkg::OFF_CHECK_CTRL;
    wire is_stat = i_paddr == clk_check_pkg::OFF_TX_STATUS;
    wire mapped  = is_ctrl || is_stat || i_paddr == clk_check_pkg::OFF_INT_MASK;
    wire rd_ans  = o_pready && !i_pwrite;
    wire wr_ans  = o_pready && i_pwrite;
    // Status bits other than the flag, and the two outputs that must be idle after reset.
    wire [30:0] stat_rest = {o_prdata[31:3], o_prdata[1:0]};
    wire        quiet     = !o_tx_interrupt && !o_autoswitch_request;

    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rstn);

    // One wait state: the answer comes in the cycle after penable rises, for one cycle.
    pready_wait_a: assert property ($rose(i_penable) && i_psel |=> o_pready)
        else $error("answer late or missing");
    pready_pulse_a: assert property (o_pready |=> !o_pready)
        else $error("ready stood longer than one cycle");
    unmapped_err_a: assert property (o_pready |-> o_pslverr == !mapped)
        else $error("error response does not match the address map");
    reserved_zero_a: assert property (rd_ans && is_ctrl |-> o_prdata[6:4] == 3'h0)
        else $error("reserved control bits read nonzero");
    status_bits_a: assert property (rd_ans && is_stat |-> stat_rest == 31'h0)
        else $error("unused status bits read nonzero");
    // The outputs may only drop because software wrote, two edges earlier.
    irq_clear_a: assert property ($fell(o_tx_interrupt) |-> $past(wr_ans, 2))
        else $error("interrupt dropped without a write");
    switch_clear_a: assert property ($fell(o_autoswitch_request) |-> $past(wr_ans, 2))
        else $error("switch request dropped without a write");
    reset_quiet_a: assert property ($rose(i_rstn) |-> quiet)
        else $error("outputs active right after reset");

    cover property ($rose(o_tx_interrupt));
    cover property ($rose(o_autoswitch_request));
    cover property (o_pslverr);
endmodule

bind tx_clock_failure_check tx_check_monitor mon_u (.i_clk(i_clk), .i_rstn(i_rstn),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .i_pwdata(i_pwdata), .i_pstrb(i_pstrb), .o_pready(o_pready), .o_prdata(o_prdata),
    .o_pslverr(o_pslverr), .i_tx_high_freq_master_clock(i_tx_high_freq_master_clock),
    .o_tx_interrupt(o_tx_interrupt), .o_autoswitch_request(o_autoswitch_request));

// >>> dv/mclk_source.sv
// Model of the external transmit master clock source.
// Assumes the half period is given in system clocks; zero holds the clock still.
`timescale 1ns/1ps

module mclk_source (
    input  wire logic       i_clk,
    input  wire logic [7:0] i_half,
    output logic            o_mclk
);
    logic [7:0] cnt_ff  = 8'h00;
    logic       mclk_ff = 1'b0;

    // One process owns the clock level, so the output has a single driver.
    assign o_mclk = mclk_ff;

    // Free running source, so every 32 of its periods form one window.
    always @(posedge i_clk) begin
        if (i_half == 8'h00) begin
            mclk_ff <= 1'b0;
            cnt_ff  <= 8'h00;
        end else if (cnt_ff + 8'h01 >= i_half) begin
            mclk_ff <= ~mclk_ff;
            cnt_ff  <= 8'h00;
        end else begin
            cnt_ff <= cnt_ff + 8'h01;
        end
    end
endmodule

// >>> dv/tx_clock_failure_check_tb.sv
// Self-checking bench for the transmit clock check block.
// Assumes the package register map and a one-wait-state APB slave.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin errors++; \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end

module tx_clock_failure_check_tb;
    logic        clk     = 1'b0;
    logic        rstn    = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [11:0] paddr   = 12'h000;
    logic [31:0] pwdata  = 32'h0000_0000;
    logic [7:0]  half    = 8'h00;
    logic [15:0] lf      = 16'h0001;
    logic        mclk, pready, pslverr, irq, sw, er;
    logic [31:0] prdata, rd;
    int          errors  = 0;
    int          checked = 0;

    always #2 clk = ~clk;

    tx_clock_failure_check dut_u (.i_clk(clk), .i_rstn(rstn), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .i_pstrb(4'hF), .o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr),
        .i_tx_high_freq_master_clock(mclk), .o_tx_interrupt(irq),
        .o_autoswitch_request(sw));
    mclk_source src_u (.i_clk(clk), .i_half(half), .o_mclk(mclk));

    function automatic logic [15:0] nxt_lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    // Ideal count: 64 half periods per window, divided by the prescaler.
    function automatic int exp_count(input int h, input int ps);
        return (((64 * h) >> ps) > 255) ? 255 : ((64 * h) >> ps);
    endfunction

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // One transfer; the request is held until pready is seen high at an edge.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            errors++;
            tally_and_finish();
        end
    endtask

    initial begin
        int h, ps, e, lo, up, m, fl;
        logic [7:0] cnt;
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        // Reset values with the master clock still, then a refused address.
        apb(1'b0, clk_check_pkg::OFF_CHECK_CTRL, 32'h0);
        `CHK("ctrl_reset", clk_check_pkg::RST_WORD, rd)
        apb(1'b0, 12'h004, 32'h0);
        `CHK("unmapped_err", 1'b1, er)
        `CHK("unmapped_rd", 32'h0, rd)
        // Every legal prescale code, random master clock rate and bound case.
        for (ps = 0; ps <= 8; ps++) begin
            lf = nxt_lfsr(lf);
            h = 2 + lf[2:0];
            half <= h[7:0];
            e = exp_count(h, ps);
            m = (ps + lf[4]) % 3;
            fl = (m == 1 && e >= 3) || (m == 2 && e <= 252);
            lo = (e >= 2) ? e - 2 : 0;
            up = (e <= 253) ? e + 2 : 255;
            up = (m == 1 && e >= 3) ? e - 3 : up;
            lo = (m == 2 && e <= 252) ? e + 3 : lo;
            apb(1'b1, clk_check_pkg::OFF_INT_MASK, {29'h0, ps[0], 2'h0});
            apb(1'b1, clk_check_pkg::OFF_CHECK_CTRL,
                {lf[15:8], up[7:0], lo[7:0], ps[1], lf[7:5], ps[3:0]});
            repeat (128 * h + 20) @(posedge clk);
            apb(1'b1, clk_check_pkg::OFF_TX_STATUS, 32'h4);
            // Stale windows have all closed by now, so a passing setup reads a clear flag.
            if (!fl) begin
                apb(1'b0, clk_check_pkg::OFF_TX_STATUS, 32'h0);
                `CHK("flag_cleared", 1'b0, rd[2])
            end
            repeat (128 * h + 20) @(posedge clk);
            apb(1'b0, clk_check_pkg::OFF_CHECK_CTRL, 32'h0);
            cnt = rd[31:24];
            `CHK("count_near", 1'b1, (cnt + 1 >= e && cnt <= e + 1))
            `CHK("ctrl_fields", {up[7:0], lo[7:0], ps[1], 3'h0, ps[3:0]}, rd[23:0])
            apb(1'b0, clk_check_pkg::OFF_TX_STATUS, 32'h0);
            `CHK("fail_flag", {29'h0, fl[0], 2'h0}, rd)
            `CHK("interrupt", fl[0] & ps[0], irq)
            `CHK("autoswitch", fl[0] & ps[1], sw)
            if (fl) begin
                apb(1'b1, clk_check_pkg::OFF_TX_STATUS, 32'h0);
                apb(1'b0, clk_check_pkg::OFF_TX_STATUS, 32'h0);
                `CHK("flag_kept", 1'b1, rd[2])
            end
        end
        tally_and_finish();
    end
endmodule
